// file: hdl/dio_pkg.sv
// Constants, register map and mode encodings for the digital I/O channel block
//
// Summary of operation
// R1: Per-input inversion applied before all mode logic
// R2: Glitch filter accepts levels after minimum width
// R3: Counter mode counts pulses while running only
// R4: Counter reset loads programmable startup value
// R5: Retain option restores saved count at power-up
// R6: Counter mode keeps inversion and filter behaviour
// R7: Rising-edge latch sets, holds until cleared
// R8: Falling-edge latch sets, holds until cleared
// R9: Frequency measured only on dedicated input channels
// R10: Direct output drives host level, reads back
// R11: Watchdog expiry drives each output's failsafe level
// R12: One module-wide enable for failsafe action
// R13: Watchdog timeout in seconds, default 720, enableable
// R14: Pulse low and high widths in 0.1 ms
// R15: Output frequency and duty derived and readable
// R16: Pulse train continuous or fixed total count
// R17: Pulse generation starts and stops on command
// R18: Rising-delay mode delays low-to-high transitions
// R19: Falling-delay mode delays high-to-low transitions
// R20: Alarm mode follows selected high or low alarm
// R21: Alarm status latched or momentary
// R22: Single 0.1 ms tick times all widths
package dio_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS        = 5;
  localparam int TICK_NS       = 100000;
  localparam int TICK_CYC      = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TICKS_PER_SEC = 10000;
  localparam int PCT_FULL      = 100;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_WDOG     = 8'h04;
  localparam logic [7:0] A_STAT     = 8'h08;
  localparam logic [7:0] A_FSV      = 8'h0c;
  localparam logic [7:0] A_ALM_CFG  = 8'h10;
  localparam logic [7:0] A_ALM_STAT = 8'h14;
  localparam logic [1:0] G_GLOBAL   = 2'h0;
  localparam logic [1:0] G_INPUT    = 2'h1;
  localparam logic [1:0] G_OUTPUT   = 2'h2;
  localparam logic [1:0] R_CFG      = 2'h0;
  localparam logic [1:0] R_WID      = 2'h1;
  localparam logic [1:0] R_VAL      = 2'h2;
  localparam logic [1:0] R_CMD      = 2'h3;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_WDOG  = 0;
  localparam int CTRL_FS    = 1;
  localparam int CFG_INV    = 3;
  localparam int CFG_FILT   = 4;
  localparam int CFG_RET    = 5;
  localparam int CFG_RUN    = 6;
  localparam int CMD_CRST   = 0;
  localparam int CMD_LCLR   = 1;
  localparam int OCFG_CONT  = 3;
  localparam int OCFG_TRIG  = 4;
  localparam int OCFG_LVL   = 5;
  localparam int OCMD_START = 0;
  localparam int OCMD_STOP  = 1;
  localparam int ALM_LO_POS = 16;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] WDOG_SEC_RST = 16'h02d0;
  localparam logic [31:0] CFG_RST      = 32'h0000_0000;
  localparam logic [31:0] STARTUP_RST  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    IM_STATUS = 3'b000,
    IM_COUNT  = 3'b001,
    IM_RISE   = 3'b011,
    IM_FALL   = 3'b010,
    IM_FREQ   = 3'b110
  } dio_in_mode_t;

  typedef enum logic [2:0] {
    OM_DIRECT = 3'b000,
    OM_PULSE  = 3'b001,
    OM_RDLY   = 3'b011,
    OM_FDLY   = 3'b010,
    OM_ALARM  = 3'b110
  } dio_out_mode_t;

endpackage : dio_pkg

// file: hdl/dio_top.sv
// Digital input and output channel logic with register port
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module dio_top import dio_pkg::*; #(
  parameter int          NUM_IN      = 4,
  parameter int          NUM_OUT     = 4,
  parameter int          TICK_CYCLES = TICK_CYC,
  parameter logic [3:0]  FREQ_OK     = 4'hf
) (
  input  wire logic               mclk,
  input  wire logic               arst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output      logic [31:0]        reg_rdata,
  input  wire logic [NUM_IN-1:0]  discrete_input_channel,
  input  wire logic [NUM_OUT-1:0] alarm_high_cond,
  input  wire logic [NUM_OUT-1:0] alarm_low_cond,
  output      logic [NUM_OUT-1:0] dout
);

  // ---------------------------------------------------------------
  // Tick and second timebase
  // ---------------------------------------------------------------
  logic [14:0] tick_cnt_reg;
  logic        tick;
  logic [13:0] sec_cnt_reg;
  logic        sec_pulse;
  logic        init_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_reg <= 15'h0000;
    end else if (tick_cnt_reg == 15'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= 15'h0000; // [R22]
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 15'h0001;
    end
  end
  assign tick = (tick_cnt_reg == 15'(TICK_CYCLES - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sec_cnt_reg <= 14'h0000;
    end else if (tick) begin
      sec_cnt_reg <= (sec_cnt_reg == 14'(TICKS_PER_SEC - 1)) ? 14'h0000 : sec_cnt_reg + 14'h0001;
    end
  end
  assign sec_pulse = tick && (sec_cnt_reg == 14'(TICKS_PER_SEC - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Global registers
  // ---------------------------------------------------------------
  logic [1:0]         ctrl_reg;
  logic [15:0]        wdog_sec_reg;
  logic [15:0]        idle_sec_reg;
  logic               expired_reg;
  logic [NUM_OUT-1:0] failsafe_output_level;
  logic [1:0]         alm_cfg_reg;
  logic               wr_glob;
  logic               host_act;

  assign wr_glob  = reg_wr && (reg_addr[7:6] == G_GLOBAL);
  assign host_act = reg_wr || reg_rd;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg              <= 2'h0;
      wdog_sec_reg          <= WDOG_SEC_RST;
      failsafe_output_level <= '0;
      alm_cfg_reg           <= 2'h0;
    end else if (wr_glob) begin
      case (reg_addr)
        A_CTRL:    ctrl_reg              <= reg_wdata[1:0];
        A_WDOG:    wdog_sec_reg          <= reg_wdata[15:0]; // [R13]
        A_FSV:     failsafe_output_level <= reg_wdata[NUM_OUT-1:0];
        A_ALM_CFG: alm_cfg_reg           <= reg_wdata[1:0];
        default:   ctrl_reg              <= ctrl_reg;
      endcase
    end
  end

  // Host-idle watchdog
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      idle_sec_reg <= 16'h0000;
      expired_reg  <= 1'b0;
    end else if (!ctrl_reg[CTRL_WDOG] || host_act) begin
      idle_sec_reg <= 16'h0000; // [R13]
      expired_reg  <= 1'b0;
    end else if (sec_pulse && !expired_reg) begin
      if (idle_sec_reg + 16'h0001 >= wdog_sec_reg) begin
        expired_reg <= 1'b1; // [R13]
      end else begin
        idle_sec_reg <= idle_sec_reg + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input channels
  // ---------------------------------------------------------------
  logic [31:0] icfg_reg  [NUM_IN];
  logic        iret_nv   [NUM_IN];
  logic [31:0] iwid_reg  [NUM_IN];
  logic [31:0] start_reg [NUM_IN];
  logic [31:0] count_reg [NUM_IN];
  logic [31:0] count_nv  [NUM_IN];
  logic [15:0] freq_reg  [NUM_IN];
  logic [15:0] edge_reg  [NUM_IN];
  logic        lvl_reg   [NUM_IN];
  logic        prev_reg  [NUM_IN];
  logic        latch_reg [NUM_IN];
  logic [15:0] flt_reg   [NUM_IN];
  logic [31:0] in_rd     [NUM_IN];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      logic         sel;
      logic         raw;
      logic         rise;
      logic         fall;
      logic         crst;
      logic         lclr;
      logic [15:0]  width;
      dio_in_mode_t mode;

      assign sel   = reg_wr && (reg_addr[7:6] == G_INPUT) && (reg_addr[5:4] == 2'(gi));
      assign mode  = dio_in_mode_t'(icfg_reg[gi][2:0]);
      assign raw   = discrete_input_channel[gi] ^ icfg_reg[gi][CFG_INV]; // [R1] [R6]
      assign width = raw ? iwid_reg[gi][31:16] : iwid_reg[gi][15:0];
      assign rise  = lvl_reg[gi] && !prev_reg[gi];
      assign fall  = !lvl_reg[gi] && prev_reg[gi];
      assign crst  = sel && (reg_addr[3:2] == R_CMD) && reg_wdata[CMD_CRST];
      assign lclr  = sel && (reg_addr[3:2] == R_CMD) && reg_wdata[CMD_LCLR];

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          icfg_reg[gi]  <= CFG_RST;
          iwid_reg[gi]  <= CFG_RST;
          start_reg[gi] <= STARTUP_RST;
        end else if (sel) begin
          case (reg_addr[3:2])
            R_CFG:   icfg_reg[gi]  <= reg_wdata;
            R_WID:   iwid_reg[gi]  <= reg_wdata;
            R_VAL:   start_reg[gi] <= reg_wdata;
            default: icfg_reg[gi]  <= icfg_reg[gi];
          endcase
        end
      end

      // Retain flag and saved count survive reset
      always_ff @(posedge mclk) begin
        if (sel && (reg_addr[3:2] == R_CFG)) begin
          iret_nv[gi] <= reg_wdata[CFG_RET];
        end
        if (!init_reg) begin
          count_nv[gi] <= count_reg[gi]; // [R5]
        end
      end

      // Glitch filter
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          lvl_reg[gi]  <= 1'b0;
          prev_reg[gi] <= 1'b0;
          flt_reg[gi]  <= 16'h0000;
        end else begin
          prev_reg[gi] <= lvl_reg[gi];
          if (raw == lvl_reg[gi]) begin
            flt_reg[gi] <= 16'h0000;
          end else if (!icfg_reg[gi][CFG_FILT]) begin
            lvl_reg[gi] <= raw;
          end else if (tick) begin
            if (17'(flt_reg[gi]) + 17'h00001 >= 17'(width)) begin
              lvl_reg[gi] <= raw; // [R2] [R6]
              flt_reg[gi] <= 16'h0000;
            end else begin
              flt_reg[gi] <= flt_reg[gi] + 16'h0001;
            end
          end
        end
      end

      // Pulse counter
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          count_reg[gi] <= 32'h0000_0000;
        end else if (init_reg) begin
          count_reg[gi] <= iret_nv[gi] ? count_nv[gi] : 32'h0000_0000; // [R5]
        end else if (crst) begin
          count_reg[gi] <= start_reg[gi]; // [R4]
        end else if ((mode == IM_COUNT) && icfg_reg[gi][CFG_RUN] && rise) begin
          count_reg[gi] <= count_reg[gi] + 32'h0000_0001; // [R3]
        end
      end

      // Edge latch, set wins over clear
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          latch_reg[gi] <= 1'b0;
        end else if ((mode == IM_RISE) && rise) begin
          latch_reg[gi] <= 1'b1; // [R7]
        end else if ((mode == IM_FALL) && fall) begin
          latch_reg[gi] <= 1'b1; // [R8]
        end else if (lclr) begin
          latch_reg[gi] <= 1'b0; // [R7] [R8]
        end
      end

      // Frequency over a one-second gate
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          edge_reg[gi] <= 16'h0000;
          freq_reg[gi] <= 16'h0000;
        end else if (!FREQ_OK[gi] || (mode != IM_FREQ)) begin
          edge_reg[gi] <= 16'h0000; // [R9]
          freq_reg[gi] <= 16'h0000;
        end else if (sec_pulse) begin
          freq_reg[gi] <= edge_reg[gi] + 16'(rise); // [R9]
          edge_reg[gi] <= 16'h0000;
        end else if (rise) begin
          edge_reg[gi] <= edge_reg[gi] + 16'h0001;
        end
      end

      always_comb begin
        case (reg_addr[3:2])
          R_CFG:   in_rd[gi] = icfg_reg[gi];
          R_WID:   in_rd[gi] = iwid_reg[gi];
          R_VAL:   in_rd[gi] = (mode == IM_FREQ) ? {16'h0000, freq_reg[gi]} : count_reg[gi];
          default: in_rd[gi] = {30'h0, latch_reg[gi], lvl_reg[gi]};
        endcase
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Output channels
  // ---------------------------------------------------------------
  logic [31:0]        ocfg_reg  [NUM_OUT];
  logic [31:0]        owid_reg  [NUM_OUT];
  logic [31:0]        opar_reg  [NUM_OUT];
  logic [15:0]        ofreq_reg [NUM_OUT];
  logic [7:0]         oduty_reg [NUM_OUT];
  logic [31:0]        out_rd    [NUM_OUT];
  logic [NUM_OUT-1:0] run_reg;
  logic [NUM_OUT-1:0] alm_hi_reg;
  logic [NUM_OUT-1:0] alm_lo_reg;
  logic               alm_clr;

  assign alm_clr = wr_glob && (reg_addr == A_ALM_STAT);

  // Alarm status, latched or momentary
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      alm_hi_reg <= '0;
      alm_lo_reg <= '0;
    end else begin
      alm_hi_reg <= alm_cfg_reg[0]
        ? (alarm_high_cond | (alm_hi_reg & ~({NUM_OUT{alm_clr}} & reg_wdata[NUM_OUT-1:0])))
        : alarm_high_cond; // [R21]
      alm_lo_reg <= alm_cfg_reg[1]
        ? (alarm_low_cond | (alm_lo_reg & ~({NUM_OUT{alm_clr}} & reg_wdata[ALM_LO_POS +: NUM_OUT])))
        : alarm_low_cond; // [R21]
    end
  end

  genvar go;
  generate
    for (go = 0; go < NUM_OUT; go++) begin : g_out
      logic          sel;
      logic          start;
      logic          stop;
      logic          phase_reg;
      logic [15:0]   ph_cnt_reg;
      logic [15:0]   pulses_reg;
      logic          dly_out_reg;
      logic [15:0]   dly_cnt_reg;
      logic          target;
      logic          slow;
      logic          sel_lvl;
      logic [16:0]   period;
      dio_out_mode_t mode;

      assign sel    = reg_wr && (reg_addr[7:6] == G_OUTPUT) && (reg_addr[5:4] == 2'(go));
      assign start  = sel && (reg_addr[3:2] == R_CMD) && reg_wdata[OCMD_START];
      assign stop   = sel && (reg_addr[3:2] == R_CMD) && reg_wdata[OCMD_STOP];
      assign mode   = dio_out_mode_t'(ocfg_reg[go][2:0]);
      assign target = ocfg_reg[go][OCFG_LVL];
      assign period = 17'(owid_reg[go][15:0]) + 17'(owid_reg[go][31:16]);
      assign slow   = ((mode == OM_RDLY) && target) || ((mode == OM_FDLY) && !target);

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          ocfg_reg[go] <= CFG_RST;
          owid_reg[go] <= CFG_RST;
          opar_reg[go] <= CFG_RST;
        end else if (sel) begin
          case (reg_addr[3:2])
            R_CFG:   ocfg_reg[go] <= reg_wdata; // [R10]
            R_WID:   owid_reg[go] <= reg_wdata; // [R14]
            R_VAL:   opar_reg[go] <= reg_wdata;
            default: ocfg_reg[go] <= ocfg_reg[go];
          endcase
        end
      end

      // Pulse generator, low phase first
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          run_reg[go] <= 1'b0;
          phase_reg   <= 1'b0;
          ph_cnt_reg  <= 16'h0000;
          pulses_reg  <= 16'h0000;
        end else if (start) begin
          run_reg[go] <= 1'b1; // [R17]
          phase_reg   <= 1'b0;
          ph_cnt_reg  <= 16'h0000;
          pulses_reg  <= 16'h0000;
        end else if (stop || (mode != OM_PULSE)) begin
          run_reg[go] <= 1'b0; // [R17]
        end else if (run_reg[go] && tick) begin
          if (17'(ph_cnt_reg) + 17'h00001 >= 17'(phase_reg ? owid_reg[go][31:16] : owid_reg[go][15:0])) begin
            ph_cnt_reg <= 16'h0000; // [R14]
            phase_reg  <= !phase_reg;
            if (phase_reg) begin
              pulses_reg <= pulses_reg + 16'h0001;
              if (!ocfg_reg[go][OCFG_CONT] && (pulses_reg + 16'h0001 >= opar_reg[go][15:0])) begin
                run_reg[go] <= 1'b0; // [R16]
              end
            end
          end else begin
            ph_cnt_reg <= ph_cnt_reg + 16'h0001;
          end
        end
      end

      // Delayed transition
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          dly_out_reg <= 1'b0;
          dly_cnt_reg <= 16'h0000;
        end else if (target == dly_out_reg) begin
          dly_cnt_reg <= 16'h0000;
        end else if (!slow) begin
          dly_out_reg <= target;
        end else if (tick) begin
          if (17'(dly_cnt_reg) + 17'h00001 >= 17'(opar_reg[go][31:16])) begin
            dly_out_reg <= target; // [R18] [R19]
            dly_cnt_reg <= 16'h0000;
          end else begin
            dly_cnt_reg <= dly_cnt_reg + 16'h0001;
          end
        end
      end

      // Frequency in Hz and duty in percent
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          ofreq_reg[go] <= 16'h0000;
          oduty_reg[go] <= 8'h00;
        end else if (period == 17'h00000) begin
          ofreq_reg[go] <= 16'h0000;
          oduty_reg[go] <= 8'h00;
        end else begin
          ofreq_reg[go] <= 16'(17'(TICKS_PER_SEC) / period); // [R15]
          oduty_reg[go] <= 8'((24'(owid_reg[go][31:16]) * 24'(PCT_FULL)) / 24'(period)); // [R15]
        end
      end

      always_comb begin
        case (mode)
          OM_DIRECT: sel_lvl = target; // [R10]
          OM_PULSE:  sel_lvl = run_reg[go] && phase_reg;
          OM_RDLY:   sel_lvl = dly_out_reg;
          OM_FDLY:   sel_lvl = dly_out_reg;
          OM_ALARM:  sel_lvl = ocfg_reg[go][OCFG_TRIG] ? alm_lo_reg[go] : alm_hi_reg[go]; // [R20]
          default:   sel_lvl = 1'b0;
        endcase
      end

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          dout[go] <= 1'b0;
        end else if (ctrl_reg[CTRL_FS] && expired_reg) begin
          dout[go] <= failsafe_output_level[go]; // [R11] [R12]
        end else begin
          dout[go] <= sel_lvl;
        end
      end

      always_comb begin
        case (reg_addr[3:2])
          R_CFG:   out_rd[go] = ocfg_reg[go];
          R_WID:   out_rd[go] = owid_reg[go];
          R_VAL:   out_rd[go] = opar_reg[go];
          default: out_rd[go] = {ofreq_reg[go], oduty_reg[go], 6'h00, run_reg[go], dout[go]}; // [R10] [R15]
        endcase
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr[7:6])
      G_GLOBAL: begin
        case (reg_addr)
          A_CTRL:     rd_mux = {30'h0, ctrl_reg};
          A_WDOG:     rd_mux = {16'h0000, wdog_sec_reg};
          A_STAT:     rd_mux = {16'h0000, idle_sec_reg[14:0], expired_reg};
          A_FSV:      rd_mux = 32'(failsafe_output_level);
          A_ALM_CFG:  rd_mux = {30'h0, alm_cfg_reg};
          A_ALM_STAT: rd_mux = (32'(alm_lo_reg) << ALM_LO_POS) | 32'(alm_hi_reg);
          default:    rd_mux = 32'h0000_0000;
        endcase
      end
      G_INPUT:  rd_mux = (32'(reg_addr[5:4]) < 32'(NUM_IN)) ? in_rd[reg_addr[5:4]] : 32'h0000_0000;
      G_OUTPUT: rd_mux = (32'(reg_addr[5:4]) < 32'(NUM_OUT)) ? out_rd[reg_addr[5:4]] : 32'h0000_0000;
      default:  rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : dio_top

// file: verification/dio_field.sv
// Field device model driving input channels and alarm conditions
`timescale 1ns/1ps
module dio_field (
  input  wire logic       mclk,
  output      logic [3:0] din,
  output      logic [3:0] ahi,
  output      logic [3:0] alo
);
  // ----------------
  // Field stimulus
  // ----------------
  initial begin
    din = 4'h0;
    ahi = 4'h0;
    alo = 4'h0;
  end
  task automatic set_in(input int c, input logic v);
    @(posedge mclk);
    din[c] <= v;
  endtask : set_in
  // Slow or fast contacts by width
  task automatic pulses(input int c, input int k, input int h, input int l);
    repeat (k) begin
      set_in(c, 1'b1);
      repeat (h) @(posedge mclk);
      set_in(c, 1'b0);
      repeat (l) @(posedge mclk);
    end
  endtask : pulses
  task automatic alarm(input int c, input logic hi, input logic lo);
    @(posedge mclk);
    ahi[c] <= hi;
    alo[c] <= lo;
  endtask : alarm
endmodule : dio_field

// file: verification/dio_top_chk.sv
// Port checker for the digital I/O channel block
`timescale 1ns/1ps
module dio_top_chk import dio_pkg::*; #(
  parameter int NUM_OUT = 4
) (
  input wire logic               mclk,
  input wire logic               arst_n,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  input wire logic [NUM_OUT-1:0] dout
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_back(a, m);
    logic [31:0] v;
    (reg_wr && reg_addr == a, v = reg_wdata & m) ##2 (reg_rd && reg_addr == a) |=> (reg_rdata & m) == v;
  endproperty
  property p_direct;
    logic l;
    (reg_wr && reg_addr == 8'h80 && reg_wdata[2:0] == 3'h0, l = reg_wdata[5]) |-> ##2 dout[0] == l;
  endproperty
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_direct_level: assert property (p_direct)
    else $error("direct level wrong");
  a_ctrl_back: assert property (p_back(A_CTRL, 32'h3))
    else $error("control readback wrong");
  a_fail_level_back: assert property (p_back(A_FSV, 32'hf))
    else $error("failsafe level readback wrong");
  a_out_wid_back: assert property (p_back(8'h94, 32'hffff_ffff))
    else $error("pulse width readback wrong");
  a_in_wid_back: assert property (p_back(8'h64, 32'hffff_ffff))
    else $error("filter width readback wrong");
  a_wdog_back: assert property (reg_wr && reg_addr == A_WDOG ##2 reg_rd && reg_addr == A_WDOG
    |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3)) else $error("timeout readback wrong");
  c_pulse_start: cover property (reg_wr && reg_addr == 8'h9c && reg_wdata[0]);
  c_delay_rise: cover property ($rose(dout[2]));
  c_fail_state: cover property (dout[1] && dout[3] && !dout[0]);
endmodule : dio_top_chk

// file: verification/test_dio_top.sv
// Self-checking bench for the digital I/O channel block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("ERROR %0t %h %h", $time, g, e); end end
module test_dio_top import dio_pkg::*; ;
  logic        mclk;
  logic        arst_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] q;
  logic [3:0]  din, ahi, alo, dout;
  int          fails = 0;
  int          comparisons = 0;
  int          n;
  // ----------------
  // Harness
  // ----------------
  dio_top #(.TICK_CYCLES(4)) dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .discrete_input_channel(din),
    .alarm_high_cond(ahi), .alarm_low_cond(alo), .dout(dout));
  dio_field fld (.mclk(mclk), .din(din), .ahi(ahi), .alo(alo));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic wt(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : wt
  task automatic cnt(input int c, input int k);
    logic p;
    p = dout[c];
    n = 0;
    repeat (k) begin
      wt(1);
      if (dout[c] && !p) n++;
      p = dout[c];
    end
  endtask : cnt
  task automatic rst();
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : rst
  task automatic tally_and_finish();
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_count();
    wr(8'h64, 32'h0002_0002);
    rd(8'h64);
    rd(8'h18);
    `CHK(q, 32'h0)
    wr(8'h68, 32'h10);
    wr(8'h60, 32'h51);
    wr(8'h6c, 32'h1);
    rd(8'h68);
    `CHK(q, 32'h10)
    fld.pulses(2, 3, 20, 20);
    fld.pulses(2, 1, 2, 20);
    rd(8'h68);
    `CHK(q, 32'h13)
    wr(8'h60, 32'h31);
    fld.pulses(2, 2, 20, 20);
    rst();
    rd(8'h68);
    `CHK(q, 32'h13)
    rd(A_WDOG);
    `CHK(q[15:0], WDOG_SEC_RST)
  endtask : t_count
  task automatic t_io();
    wr(8'h80, 32'h20);
    wt(3);
    `CHK(dout[0], 1'b1)
    wr(8'h40, 32'h3);
    wr(8'h50, 32'ha);
    wt(3);
    wr(8'h5c, 32'h2);
    fld.set_in(0, 1'b1);
    fld.set_in(1, 1'b1);
    fld.set_in(0, 1'b0);
    wt(4);
    rd(8'h4c);
    `CHK(q[1], 1'b1)
    rd(8'h5c);
    `CHK(q[1], 1'b1)
    wr(8'h4c, 32'h2);
    rd(8'h4c);
    `CHK(q[1], 1'b0)
  endtask : t_io
  task automatic t_pulse();
    wr(8'h94, 32'h0002_0001);
    rd(8'h94);
    wr(8'h98, 32'h2);
    wr(8'h90, 32'h1);
    wr(8'h9c, 32'h1);
    cnt(1, 150);
    `CHK(n, 2)
    rd(8'h9c);
    `CHK(q[31:8], {16'd3333, 8'd66})
    wr(8'h90, 32'h9);
    wr(8'h9c, 32'h1);
    cnt(1, 60);
    `CHK(n > 3, 1'b1)
    wr(8'h9c, 32'h2);
    wt(3);
    cnt(1, 60);
    `CHK(n, 0)
  endtask : t_pulse
  task automatic t_delay();
    wr(8'ha8, 32'h0005_0000);
    wr(8'ha0, 32'h23);
    wt(10);
    `CHK(dout[2], 1'b0)
    wt(20);
    `CHK(dout[2], 1'b1)
    wr(8'ha0, 32'h22);
    wr(8'ha0, 32'h2);
    wt(10);
    `CHK(dout[2], 1'b1)
    wt(20);
    `CHK(dout[2], 1'b0)
  endtask : t_delay
  task automatic t_alarm();
    wr(8'hb0, 32'h6);
    fld.alarm(3, 1'b1, 1'b0);
    wt(4);
    `CHK(dout[3], 1'b1)
    fld.alarm(3, 1'b0, 1'b0);
    wt(4);
    `CHK(dout[3], 1'b0)
    wr(A_ALM_CFG, 32'h1);
    fld.alarm(3, 1'b1, 1'b0);
    fld.alarm(3, 1'b0, 1'b0);
    wt(4);
    `CHK(dout[3], 1'b1)
    wr(A_ALM_STAT, 32'h8);
    wt(4);
    `CHK(dout[3], 1'b0)
    wr(8'hb0, 32'h16);
    fld.alarm(3, 1'b0, 1'b1);
    wt(4);
    `CHK(dout[3], 1'b1)
  endtask : t_alarm
  task automatic t_wdog();
    wr(8'h70, 32'h6);
    fld.pulses(3, 5, 4, 4);
    wr(A_FSV, 32'ha);
    rd(A_FSV);
    wr(A_WDOG, 32'h1);
    rd(A_WDOG);
    wr(A_CTRL, 32'h3);
    rd(A_CTRL);
    n = 0;
    while (dout !== 4'ha && n < 60000) begin
      wt(1);
      n++;
    end
    `CHK(dout, 4'ha)
    rd(8'h78);
    `CHK(q, 32'h5)
  endtask : t_wdog
  initial begin
    rst();
    t_count();
    t_io();
    t_pulse();
    t_delay();
    t_alarm();
    t_wdog();
    tally_and_finish();
  end
  initial begin
    #350000;
    fails++;
    tally_and_finish();
  end
endmodule : test_dio_top
bind dio_top dio_top_chk #(.NUM_OUT(NUM_OUT)) u_chk (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dout(dout));
